// File: pkg/vmx_pkg.sv
// Package: constants and carriers of the video matrix control block
`default_nettype none
package vmx_pkg;
  // ---------------------------------------------------------------
  // Register pointers and address fields
  // ---------------------------------------------------------------
  localparam logic [1:0] ROUTE_REG = 2'h0;
  localparam logic [1:0] GCA_REG = 2'h1;
  localparam logic [1:0] OEN_REG = 2'h2;
  localparam logic [1:0] LAST_REG = 2'h2;
  localparam logic [3:0] DEV_ADDR_HI = 4'h9;
  localparam logic [2:0] NONBUS_STRAP = 3'h7;
  localparam logic [5:0] SUB_HI_ZERO = 6'h00;

  // ---------------------------------------------------------------
  // Bit counting of the serial slave
  // ---------------------------------------------------------------
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] ACK_SLOT = 4'h9;

  // ---------------------------------------------------------------
  // Strap settling and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] STRAP_SETTLE = 2'h2;
  localparam logic [7:0] ROUTE_RST = 8'h00;
  localparam logic [7:0] GCA_RST = 8'h00;
  localparam logic [3:0] OEN_RST = 4'h0;
  localparam logic [3:0] ALL_ON = 4'hf;
  localparam logic [1:0] CLAMP_HI_OFF = 2'h3;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0][1:0] route_code;
    logic [3:0] gain_select_bit;
    logic [3:0] output_drive_enable;
    logic [3:0] clamp_disable;
    logic [1:0] aux_logic_out;
  } matrix_ctrl_t;

  typedef struct packed {
    logic tgl;
    logic [1:0] ptr;
    logic [7:0] data;
  } reg_write_t;

  localparam matrix_ctrl_t CTRL_RST = '{route_code: 8'h00, gain_select_bit: 4'h0,
    output_drive_enable: 4'h0, clamp_disable: 4'hc, aux_logic_out: 2'h0};
endpackage : vmx_pkg
`default_nettype wire

// File: design/serial_write_slave.sv
// Serial write-only slave receiver running on the link clock
`default_nettype none
module serial_write_slave (
  // Clock and reset
  input wire logic link_clk_i,
  input wire logic rstn_i,
  // Serial pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  // Quasi-static settings from the control domain
  input wire logic [2:0] strap_addr_i,
  input wire logic bus_off_i,
  // Register write event, toggle qualified
  output var vmx_pkg::reg_write_t wr_o
);
  typedef enum logic [1:0] {PH_IDLE = 2'b00, PH_ADDR = 2'b01, PH_SUB = 2'b10, PH_DATA = 2'b11} phase_t;

  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic scl_d;
    logic sda_d;
    logic [2:0] strap_s1;
    logic [2:0] strap_s2;
    logic off_s1;
    logic off_s2;
    phase_t phase;
    logic [3:0] bits;
    logic [7:0] shreg;
    logic ack;
    logic wr_due;
    logic [1:0] ptr;
    vmx_pkg::reg_write_t wr;
  } slave_st_t;

  slave_st_t st_ff;
  slave_st_t nxt_st;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  // ---------------------------------------------------------------
  // Framing, byte assembly and acknowledge
  // ---------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.scl_s = {st_ff.scl_s[0], scl_i};
    nxt_st.sda_s = {st_ff.sda_s[0], sda_i};
    nxt_st.scl_d = st_ff.scl_s[1];
    nxt_st.sda_d = st_ff.sda_s[1];
    nxt_st.strap_s1 = strap_addr_i;
    nxt_st.strap_s2 = st_ff.strap_s1;
    nxt_st.off_s1 = bus_off_i;
    nxt_st.off_s2 = st_ff.off_s1;
    scl_rise = st_ff.scl_s[1] & ~st_ff.scl_d;
    scl_fall = ~st_ff.scl_s[1] & st_ff.scl_d;
    start_seen = st_ff.scl_s[1] & st_ff.scl_d & st_ff.sda_d & ~st_ff.sda_s[1];
    stop_seen = st_ff.scl_s[1] & st_ff.scl_d & ~st_ff.sda_d & st_ff.sda_s[1];
    if (start_seen) begin
      nxt_st.phase = PH_ADDR;
      nxt_st.bits = 4'h0;
      nxt_st.ack = 1'b0;
      nxt_st.wr_due = 1'b0;
    end else if (stop_seen) begin
      nxt_st.phase = PH_IDLE;
      nxt_st.bits = 4'h0;
      nxt_st.ack = 1'b0;
      nxt_st.wr_due = 1'b0;
    end else if (st_ff.phase != PH_IDLE) begin
      if (scl_rise && st_ff.bits < vmx_pkg::BYTE_BITS) begin
        nxt_st.shreg = {st_ff.shreg[6:0], st_ff.sda_s[1]};
        nxt_st.bits = st_ff.bits + 4'h1;
      end else if (scl_fall && st_ff.bits == vmx_pkg::BYTE_BITS) begin
        nxt_st.bits = vmx_pkg::ACK_SLOT;
        unique case (st_ff.phase)
          PH_IDLE: nxt_st.ack = 1'b0;
          PH_ADDR: nxt_st.ack = !st_ff.off_s2 &&
            st_ff.shreg == {vmx_pkg::DEV_ADDR_HI, st_ff.strap_s2, 1'b0};
          PH_SUB: begin
            nxt_st.ack = st_ff.shreg[7:2] == vmx_pkg::SUB_HI_ZERO;
            nxt_st.ptr = st_ff.shreg[1:0];
          end
          PH_DATA: begin
            nxt_st.ack = 1'b1;
            nxt_st.wr_due = 1'b1;
          end
        endcase
      end else if (scl_fall && st_ff.bits == vmx_pkg::ACK_SLOT) begin
        nxt_st.ack = 1'b0;
        nxt_st.bits = 4'h0;
        if (!st_ff.ack) begin
          nxt_st.phase = PH_IDLE;
        end else if (st_ff.phase == PH_ADDR) begin
          nxt_st.phase = PH_SUB;
        end else if (st_ff.phase == PH_SUB) begin
          nxt_st.phase = PH_DATA;
        end
        // Publish the byte after its acknowledge, then step the pointer
        if (st_ff.wr_due) begin
          nxt_st.wr_due = 1'b0;
          if (st_ff.ptr <= vmx_pkg::LAST_REG) begin
            nxt_st.wr = '{tgl: ~st_ff.wr.tgl, ptr: st_ff.ptr, data: st_ff.shreg};
          end
          nxt_st.ptr = (st_ff.ptr >= vmx_pkg::LAST_REG) ? vmx_pkg::ROUTE_REG : st_ff.ptr + 2'h1;
        end
      end
    end
  end

  // State register
  always_ff @(posedge link_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_ff <= '{phase: PH_IDLE, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Open-drain acknowledge: drive low only
  assign sda_o = 1'b0;
  assign sda_oe_n_o = ~st_ff.ack;
  assign wr_o = st_ff.wr;
endmodule : serial_write_slave
`default_nettype wire

// File: design/video_matrix_control_regs.sv
// Control registers and mode logic of a 4x4 video switch matrix
`default_nettype none
// Overview of operation
// - Each output routes the input numbered by its two-bit select code.
// - Register 01H holds gain, clamp, aux; bits 7..4 gain for outputs 3..0.
// - Gain bit 0 gives gain two, bit 1 gives gain one.
// - Bits 3,2 set clamping of inputs 1,0; 0 clamps, 1 mean-value bias.
// - Bits 1,0 drive auxiliary outputs 1,0 directly; 0 low, 1 high.
// - Register 02H bits 3..0 enable outputs 3..0; upper bits ignored.
// - Bus-mode reset: outputs off, input 0, gain two, inputs 0,1 clamped.
// - All three straps high selects non-bus mode; bus traffic ignored.
// - Non-bus mode: gain two, all inputs clamped, all outputs active.
// - Non-bus mode takes clock and data pin levels as static selects.
// - Clock pin high swaps outputs 3,2 with outputs 1,0.
// - Data pin high swaps 3 with 2 and 1 with 0; route is j xor pins.
// - After power-up both auxiliary outputs are low.
// - Register 00H holds select codes, bits 7:6 for output 3 down.
// - Pointer steps per data byte and wraps after the third register.
// - Address is 1001 plus straps, write only; device acknowledges bytes.
module video_matrix_control_regs (
  // Control clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // Link clock for the serial slave
  input wire logic link_clk_i,
  // Serial pins, data is open drain
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  // Address straps
  input wire logic strap_addr_bit0_i,
  input wire logic strap_addr_bit1_i,
  input wire logic strap_addr_bit2_i,
  // Matrix controls
  output var vmx_pkg::matrix_ctrl_t ctrl_o,
  output logic nonbus_mode_o
);
  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic [2:0] strap_s1;
    logic [2:0] strap_s2;
    logic [1:0] settle;
    logic caught;
    logic nonbus;
    logic bus_off;
    logic [2:0] strap;
    logic [2:0] tgl_s;
    logic [7:0] routing_select_register;
    logic [7:0] gain_clamp_aux_control;
    logic [3:0] output_enable_control;
    vmx_pkg::matrix_ctrl_t ctrl;
  } top_st_t;

  top_st_t st_ff;
  top_st_t nxt_st;
  vmx_pkg::reg_write_t wr;
  logic wr_event;
  logic [1:0] pin_code;

  // ---------------------------------------------------------------
  // Serial slave in the link domain
  // ---------------------------------------------------------------
  serial_write_slave slave_u (
    .link_clk_i(link_clk_i),
    .rstn_i(rstn_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n_o),
    .strap_addr_i(st_ff.strap),
    .bus_off_i(st_ff.bus_off),
    .wr_o(wr)
  );

  // ---------------------------------------------------------------
  // Control domain state
  // ---------------------------------------------------------------
  assign wr_event = st_ff.tgl_s[1] ^ st_ff.tgl_s[2];
  assign pin_code = {st_ff.scl_s[1], st_ff.sda_s[1]};

  // Synchronisers, strap capture, register writes and output mapping
  always_comb begin
    nxt_st = st_ff;
    nxt_st.scl_s = {st_ff.scl_s[0], scl_i};
    nxt_st.sda_s = {st_ff.sda_s[0], sda_i};
    nxt_st.strap_s1 = {strap_addr_bit2_i, strap_addr_bit1_i, strap_addr_bit0_i};
    nxt_st.strap_s2 = st_ff.strap_s1;
    nxt_st.tgl_s = {st_ff.tgl_s[1], st_ff.tgl_s[0], wr.tgl};
    // Straps are taken once, after they have passed the synchroniser
    if (st_ff.settle != vmx_pkg::STRAP_SETTLE) begin
      nxt_st.settle = st_ff.settle + 2'h1;
    end else if (!st_ff.caught) begin
      nxt_st.caught = 1'b1;
      nxt_st.strap = st_ff.strap_s2;
      nxt_st.nonbus = st_ff.strap_s2 == vmx_pkg::NONBUS_STRAP;
    end
    // Registered and one cycle behind the capture, so the slave sees a settled strap copy first
    nxt_st.bus_off = ~st_ff.caught | st_ff.nonbus;
    // Data word is stable while the toggle edge crosses
    if (wr_event) begin
      if (wr.ptr == vmx_pkg::ROUTE_REG) begin
        nxt_st.routing_select_register = wr.data;
      end else if (wr.ptr == vmx_pkg::GCA_REG) begin
        nxt_st.gain_clamp_aux_control = wr.data;
      end else if (wr.ptr == vmx_pkg::OEN_REG) begin
        nxt_st.output_enable_control = wr.data[3:0];
      end
    end
    if (!st_ff.caught) begin
      nxt_st.ctrl = vmx_pkg::CTRL_RST;
    end else if (st_ff.nonbus) begin
      for (int j = 0; j < 4; j++) begin
        nxt_st.ctrl.route_code[j] = 2'(j) ^ pin_code;
      end
      nxt_st.ctrl.gain_select_bit = 4'h0;
      nxt_st.ctrl.output_drive_enable = vmx_pkg::ALL_ON;
      nxt_st.ctrl.clamp_disable = 4'h0;
      nxt_st.ctrl.aux_logic_out = 2'h0;
    end else begin
      nxt_st.ctrl.route_code = st_ff.routing_select_register;
      nxt_st.ctrl.gain_select_bit = st_ff.gain_clamp_aux_control[7:4];
      nxt_st.ctrl.clamp_disable = {vmx_pkg::CLAMP_HI_OFF, st_ff.gain_clamp_aux_control[3:2]};
      nxt_st.ctrl.aux_logic_out = st_ff.gain_clamp_aux_control[1:0];
      nxt_st.ctrl.output_drive_enable = st_ff.output_enable_control;
    end
  end

  // State register
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_ff <= '{routing_select_register: vmx_pkg::ROUTE_RST, gain_clamp_aux_control: vmx_pkg::GCA_RST,
        output_enable_control: vmx_pkg::OEN_RST, ctrl: vmx_pkg::CTRL_RST, bus_off: 1'b1, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign ctrl_o = st_ff.ctrl;
  assign nonbus_mode_o = st_ff.nonbus;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rstn_i);

  a_route_bus: assert property (st_ff.caught && !st_ff.nonbus |=>
    ctrl_o.route_code == $past(st_ff.routing_select_register)) else $error("route code mismatch");
  a_gain_bits: assert property (st_ff.caught && !st_ff.nonbus |=>
    ctrl_o.gain_select_bit == $past(st_ff.gain_clamp_aux_control[7:4])) else $error("gain mismatch");
  a_clamp_bits: assert property (st_ff.caught && !st_ff.nonbus |=>
    ctrl_o.clamp_disable == {2'h3, $past(st_ff.gain_clamp_aux_control[3:2])}) else $error("clamp mismatch");
  a_aux_bits: assert property (st_ff.caught && !st_ff.nonbus |=>
    ctrl_o.aux_logic_out == $past(st_ff.gain_clamp_aux_control[1:0])) else $error("aux mismatch");
  a_enable_bits: assert property (st_ff.caught && !st_ff.nonbus |=>
    ctrl_o.output_drive_enable == $past(st_ff.output_enable_control)) else $error("enable mismatch");
  a_reset_hold: assert property (!st_ff.caught |=> ctrl_o == vmx_pkg::CTRL_RST)
    else $error("outputs left reset state early");
  a_nonbus_fixed: assert property (st_ff.nonbus |=> ctrl_o.gain_select_bit == 4'h0 &&
    ctrl_o.output_drive_enable == 4'hf && ctrl_o.clamp_disable == 4'h0) else $error("non-bus fixed state");
  a_nonbus_route: assert property ((st_ff.nonbus && $stable({scl_i, sda_i})) [*4] |->
    ctrl_o.route_code == {2'h3 ^ {scl_i, sda_i}, 2'h2 ^ {scl_i, sda_i}, 2'h1 ^ {scl_i, sda_i}, {scl_i, sda_i}})
    else $error("non-bus routing mismatch");
  a_write_gain: assert property (wr_event && wr.ptr == vmx_pkg::GCA_REG |=>
    st_ff.gain_clamp_aux_control == $past(wr.data)) else $error("register write lost");

  // Writes to the routing and enable registers land whole, upper enable bits dropped
  a_write_route: assert property (wr_event && wr.ptr == vmx_pkg::ROUTE_REG |=>
    st_ff.routing_select_register == $past(wr.data)) else $error("routing write lost");
  a_write_enable: assert property (wr_event && wr.ptr == vmx_pkg::OEN_REG |=>
    st_ff.output_enable_control == $past(wr.data[3:0])) else $error("enable write lost");

  // Registers change only when a write event crosses over
  a_regs_quiet: assert property (!wr_event |=> $stable(st_ff.gain_clamp_aux_control) &&
    $stable(st_ff.routing_select_register) && $stable(st_ff.output_enable_control))
    else $error("register changed without write");

  // Strapped mode is fixed after capture and shuts out serial writes
  a_mode_held: assert property (st_ff.caught |=> $stable(nonbus_mode_o) && st_ff.caught)
    else $error("mode changed after capture");
  a_nonbus_quiet: assert property (st_ff.nonbus |-> !wr_event)
    else $error("register write in non-bus mode");

  // Before capture the aux outputs sit low and every video output is off
  a_aux_power: assert property (!st_ff.caught |=> ctrl_o.aux_logic_out == 2'h0 &&
    ctrl_o.output_drive_enable == 4'h0) else $error("power-up aux or enable state");

  // Per-output checks of the select field position and the pin routing
  for (genvar j = 0; j < 4; j++) begin : g_out_chk
    a_route_field: assert property (st_ff.caught && !st_ff.nonbus |=>
      ctrl_o.route_code[j] == $past(st_ff.routing_select_register[2*j+1 -: 2])) else $error("route field mismatch");
    a_pin_route: assert property ((st_ff.nonbus && $stable({scl_i, sda_i})) [*4] |->
      ctrl_o.route_code[j] == (2'(j) ^ {scl_i, sda_i})) else $error("pin routing mismatch");
  end
endmodule : video_matrix_control_regs
`default_nettype wire

// File: tb/i2c_master_model.sv
// Behavioural serial bus master that writes frames to the control block
`default_nettype none
module i2c_master_model (
  // Link clock
  input wire logic link_clk_i,
  // Resolved data line level
  input wire logic sda_i,
  // Open drain drives, 1 = released
  output logic scl_o,
  output logic sda_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // Bus timing
  // ---------------------------------------------------------------
  // Idle bus: both lines released
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // Wait a number of link clock edges
  task automatic tick(input int n);
    repeat (n) @(posedge link_clk_i);
  endtask : tick
  // One byte MSB first, then sample the acknowledge in the 9th pulse
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_o <= b[i];
      tick(3);
      scl_o <= 1'b1;
      tick(6);
      scl_o <= 1'b0;
      tick(3);
    end
    sda_o <= 1'b1;
    tick(3);
    scl_o <= 1'b1;
    tick(3);
    ack = !sda_i;
    tick(3);
    scl_o <= 1'b0;
    tick(3);
  endtask : send_byte
  // Start, address, sub byte and data, then stop; write direction only
  task automatic write_frame(input logic [7:0] frm[$], output logic [7:0] acks);
    acks = 8'h00;
    tick(6);
    sda_o <= 1'b0;
    tick(6);
    scl_o <= 1'b0;
    tick(3);
    foreach (frm[i]) send_byte(frm[i], acks[i]);
    sda_o <= 1'b0;
    tick(3);
    scl_o <= 1'b1;
    tick(6);
    sda_o <= 1'b1;
    tick(6);
  endtask : write_frame
endmodule : i2c_master_model
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench of the video matrix control block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i, link_clk_i, rstn_i, pin_mode, m_scl, m_sda, sda_o, sda_oe_n_o, nonbus_mode_o;
  logic [1:0] sel_lvl;
  logic [2:0] strap;
  logic [7:0] acks, r0, r1, r2, r3, adr;
  logic [7:0] frm[$];
  vmx_pkg::matrix_ctrl_t ctrl_o, exp_c;
  vmx_pkg::matrix_ctrl_t exp_q[$];
  int err_total, cmp_count, seed;
  event chk_ev;
  wire scl_w;
  wire sda_w;
  // Static selects in pin mode, pulled-up open drain bus otherwise
  assign scl_w = pin_mode ? sel_lvl[1] : m_scl;
  assign sda_w = pin_mode ? sel_lvl[0] : (m_sda & (sda_oe_n_o | sda_o));
  // ---------------------------------------------------------------
  // Clocks, design and partner
  // ---------------------------------------------------------------
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    link_clk_i = 1'b0;
    #7;
    forever #15 link_clk_i = ~link_clk_i;
  end
  video_matrix_control_regs dut_u (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .link_clk_i(link_clk_i),
    .scl_i(scl_w), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .strap_addr_bit0_i(strap[0]),
    .strap_addr_bit1_i(strap[1]), .strap_addr_bit2_i(strap[2]), .ctrl_o(ctrl_o), .nonbus_mode_o(nonbus_mode_o));
  i2c_master_model m_u (.link_clk_i(link_clk_i), .sda_i(sda_w), .scl_o(m_scl), .sda_o(m_sda));
  // ---------------------------------------------------------------
  // Checking
  // ---------------------------------------------------------------
  // Compare a single-bit result
  task automatic cmp_bit(input logic got, input logic exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: %s got %b expected %b", $time, msg, got, exp);
    end
  endtask : cmp_bit
  // Compare the matrix controls against a noted expectation
  task automatic cmp_ctrl(input vmx_pkg::matrix_ctrl_t got, input vmx_pkg::matrix_ctrl_t exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: controls %h expected %h", $time, got, exp);
    end
  endtask : cmp_ctrl
  // Watcher takes the oldest expected controls when a result is due
  always @(chk_ev) begin
    cmp_ctrl(ctrl_o, exp_q.pop_front());
  end
  // Note the expected controls, let the watcher look once outputs settled, realign to the edge
  task automatic note_ctrl(input vmx_pkg::matrix_ctrl_t e);
    exp_q.push_back(e);
    #1;
    -> chk_ev;
    @(posedge ref_clk_i);
  endtask : note_ctrl
  // Controls implied by the three bus registers
  function automatic vmx_pkg::matrix_ctrl_t bus_exp(input logic [7:0] rt, gc, oe);
    return '{route_code: rt, gain_select_bit: gc[7:4], output_drive_enable: oe[3:0],
      clamp_disable: {2'h3, gc[3:2]}, aux_logic_out: gc[1:0]};
  endfunction : bus_exp
  // Reset with given straps, then let the strap copy settle
  task automatic do_reset(input logic [2:0] s);
    @(posedge ref_clk_i);
    rstn_i <= 1'b0;
    strap <= s;
    repeat (16) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    repeat (12) @(posedge ref_clk_i);
  endtask : do_reset
  // Send a frame and compare every acknowledge
  task automatic frame_chk(input logic [7:0] exp_ack);
    m_u.write_frame(frm, acks);
    foreach (frm[i]) cmp_bit(acks[i], exp_ack[i], "ack");
    repeat (40) @(posedge ref_clk_i);
  endtask : frame_chk
  // Print counts and verdict, then end the run
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    #300us;
    err_total++;
    report_and_stop();
  end
  initial begin
    seed = 65147;
    rstn_i = 1'b0;
    pin_mode = 1'b0;
    sel_lvl = 2'h0;
    strap = 3'h0;
    err_total = 0;
    cmp_count = 0;
    do_reset(3'({$random(seed)} % 7));
    adr = {vmx_pkg::DEV_ADDR_HI, strap, 1'b0};
    note_ctrl(vmx_pkg::CTRL_RST);
    cmp_bit(nonbus_mode_o, 1'b0, "mode");
    cmp_bit(sda_oe_n_o, 1'b1, "sda idle");
    cmp_bit(sda_o, 1'b0, "sda level");
    r0 = 8'($random(seed));
    r1 = 8'($random(seed));
    r2 = 8'($random(seed));
    r3 = 8'($random(seed));
    // Four data bytes: the fourth rewrites the routing register
    frm = '{adr, 8'h00, r0, r1, r2, r3};
    frame_chk(8'h3f);
    note_ctrl(bus_exp(r3, r1, r2));
    // Start at the enable register, next byte wraps to routing
    r0 = 8'($random(seed));
    frm = '{adr, 8'h02, {4'ha, r1[3:0]}, r0};
    frame_chk(8'h0f);
    note_ctrl(bus_exp(r0, r1, {4'h0, r1[3:0]}));
    // Refused frames leave every control unchanged
    frm = '{{vmx_pkg::DEV_ADDR_HI, strap ^ 3'h1, 1'b0}, 8'h00, 8'hff};
    frame_chk(8'h00);
    frm = '{{vmx_pkg::DEV_ADDR_HI, strap, 1'b1}, 8'h00, 8'hff};
    frame_chk(8'h00);
    frm = '{adr, 8'h04, 8'hff};
    frame_chk(8'h01);
    note_ctrl(bus_exp(r0, r1, {4'h0, r1[3:0]}));
    // Strapped pin mode: routing follows the two pin levels
    pin_mode <= 1'b1;
    do_reset(vmx_pkg::NONBUS_STRAP);
    cmp_bit(nonbus_mode_o, 1'b1, "mode");
    for (int v = 0; v < 4; v++) begin
      sel_lvl <= 2'(v);
      repeat (10) @(posedge ref_clk_i);
      for (int j = 0; j < 4; j++) exp_c.route_code[j] = 2'(j) ^ 2'(v);
      note_ctrl('{route_code: exp_c.route_code, gain_select_bit: 4'h0, output_drive_enable: 4'hf,
        clamp_disable: 4'h0, aux_logic_out: 2'h0});
    end
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
